// ===== design/pbu_map.svh
`ifndef PBU_MAP_SVH
`define PBU_MAP_SVH
// Break control field positions
`define PBU_CTL_IE 0
`define PBU_CTL_COND_LO 1
`define PBU_CTL_COND_HI 2
`define PBU_CTL_MASK_LO 3
`define PBU_CTL_MASK_HI 5
`define PBU_CTL_MASTER 6
`define PBU_CTL_FLAG 7
// Reset values
`define PBU_CTL_RESET 7'h00
`define PBU_ADDR_RESET 24'h00_0000
// Timing in states, one state per clock
`define PBU_IBLOCK_STATES 3
`endif

// ===== design/pbu_pkg.sv
package pbu_pkg;
	// Break condition select
	typedef enum logic [1:0] {
		PBU_COND_FETCH = 2'b00,
		PBU_COND_READ = 2'b01,
		PBU_COND_WRITE = 2'b10,
		PBU_COND_RW = 2'b11
	} pbu_cond_t;
	// Kind of power-down transition a sleep instruction requests
	typedef enum logic [1:0] {
		PBU_SLP_NAP = 2'b00,
		PBU_SLP_SWITCH = 2'b01,
		PBU_SLP_STANDBY = 2'b10
	} pbu_sleep_t;
endpackage

// ===== design/pbu_addr_match.sv
`timescale 1ns/100ps
`default_nettype none
module pbu_addr_match #(
	parameter int ADDR_W = 24
) (
	input wire logic [ADDR_W-1:0] ref_addr,
	input wire logic [2:0] mask_code,
	input wire logic [ADDR_W-1:0] probe_addr,
	output logic hit
);
	logic [4:0] ignore_bits;
	logic [ADDR_W-1:0] care;

	// Mask code to count of ignored low bits
	always_comb begin
		unique case (mask_code)
			3'h0: ignore_bits = 5'h00;
			3'h1: ignore_bits = 5'h01;
			3'h2: ignore_bits = 5'h02;
			3'h3: ignore_bits = 5'h03;
			3'h4: ignore_bits = 5'h04;
			3'h5: ignore_bits = 5'h08;
			3'h6: ignore_bits = 5'h0c;
			3'h7: ignore_bits = 5'h10;
		endcase
	end

	// Compare only the bits left unmasked
	assign care = {ADDR_W{1'b1}} << ignore_bits;
	assign hit = ((probe_addr ^ ref_addr) & care) == '0;
endmodule // pbu_addr_match
`default_nettype wire

// ===== design/pbu_break.sv
// Behaviour
// - Fetch break flags before instruction executes
// - Codes 01, 10, 11 compare data cycles
// - Data break flags after instruction finishes
// - Stack and branch-address reads count as data
// - Mask field bits 3-5 ignore low bits
// - Interrupt only while enable bit 0 set
// - Byte block move defers until instruction ends
// - Transfer-controller hit waits for transfer end
// - Nap sleep suppressed, break then next instruction
// - Mode switch completes first, then break
// - Standby: flag set, break request held until code runs again
// - Enable adds state to on-chip branches
// - On-chip data access to fetch-break address adds state
// - Slow preceding instruction adds state on break
// - Starts stopped; registers inaccessible until released
// - Both channels share one interrupt request
// - Flags sticky; clear by read 1, write 0
// - Transfer-controller break waits for CPU bus
// - Unexecuted prefetch after branch never breaks
// - Control-register mask update blocks three states
// - Fetch break after conditional branch if executed
// - Mask codes ignore 0,1,2,3,4,8,12,16 bits
// - Condition and master select encodings
// - Break address 24 bits, reset zero
`timescale 1ns/100ps
`default_nettype none
`include "pbu_map.svh"
module pbu_break #(
	parameter int ADDR_W = 24
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic module_stop,
	input wire logic [1:0] addr_write,
	input wire logic [ADDR_W-1:0] addr_wdata,
	input wire logic [1:0] ctrl_write,
	input wire logic [7:0] ctrl_wdata,
	input wire logic [1:0] ctrl_read,
	input wire logic bus_valid,
	input wire logic bus_fetch,
	input wire logic bus_write,
	input wire logic bus_dtc,
	input wire logic bus_onchip,
	input wire logic [ADDR_W-1:0] bus_addr,
	input wire logic insn_exec,
	input wire logic [ADDR_W-1:0] exec_addr,
	input wire logic insn_branch1,
	input wire logic insn_onchip,
	input wire logic prev_slow,
	input wire logic insn_end,
	input wire logic block_move_busy,
	input wire logic xfer_count_done,
	input wire logic xfer_irq_sel_done,
	input wire logic cpu_owns_bus,
	input wire logic sleep_exec,
	input wire pbu_pkg::pbu_sleep_t sleep_kind,
	input wire logic [ADDR_W-1:0] sleep_next_addr,
	input wire logic mode_switch_done,
	input wire logic mask_update,
	output wire logic [ADDR_W-1:0] chan_a_match_address,
	output wire logic [ADDR_W-1:0] chan_b_match_address,
	output wire logic [7:0] chan_a_break_control,
	output wire logic [7:0] chan_b_break_control,
	output logic break_irq,
	output logic extra_state,
	output logic suppress_sleep
);
	import pbu_pkg::*;

	localparam int NCH = 2;

	logic [ADDR_W-1:0] match_addr [NCH];
	logic [6:0] ctrl [NCH];
	logic flag [NCH];
	logic armed [NCH];
	logic pend_data [NCH];
	logic pend_dtc [NCH];
	logic dtc_done [NCH];
	logic pend_switch [NCH];
	logic fetch_hit [NCH];
	logic extra_term [NCH];
	logic nap_hit [NCH];
	logic standby_hit [NCH];
	logic running;
	logic standby_hold;
	logic [1:0] block_cnt;
	logic next_irq, next_extra, next_suppress, next_standby_hold;
	logic [1:0] next_block;

	assign running = !module_stop;

	// Register images; upper address bits simply do not exist
	assign chan_a_match_address = match_addr[0];
	assign chan_b_match_address = match_addr[1];
	assign chan_a_break_control = {flag[0], ctrl[0]};
	assign chan_b_break_control = {flag[1], ctrl[1]};

	// One comparator set per channel, no sharing between them
	for (genvar i = 0; i < NCH; i++) begin : g_chan
		logic exec_eq, bus_eq, next_eq;
		logic any_master, data_hit, cycle_ok, set_flag, clr_flag;
		pbu_cond_t cond;
		logic [ADDR_W-1:0] next_addr;
		logic [6:0] next_ctrl;
		logic next_flag, next_armed, next_pd, next_pt, next_dd, next_ps;

		pbu_addr_match #(.ADDR_W(ADDR_W)) u_exec (
			.ref_addr(match_addr[i]),
			.mask_code(ctrl[i][`PBU_CTL_MASK_HI:`PBU_CTL_MASK_LO]),
			.probe_addr(exec_addr),
			.hit(exec_eq)
		);
		pbu_addr_match #(.ADDR_W(ADDR_W)) u_bus (
			.ref_addr(match_addr[i]),
			.mask_code(ctrl[i][`PBU_CTL_MASK_HI:`PBU_CTL_MASK_LO]),
			.probe_addr(bus_addr),
			.hit(bus_eq)
		);
		pbu_addr_match #(.ADDR_W(ADDR_W)) u_sleep (
			.ref_addr(match_addr[i]),
			.mask_code(ctrl[i][`PBU_CTL_MASK_HI:`PBU_CTL_MASK_LO]),
			.probe_addr(sleep_next_addr),
			.hit(next_eq)
		);

		assign any_master = ctrl[i][`PBU_CTL_MASTER];
		assign cond = pbu_cond_t'(ctrl[i][`PBU_CTL_COND_HI:`PBU_CTL_COND_LO]);

		// Core only reports instructions it executes, so a dropped prefetch
		// or a skipped branch successor never reaches the comparator
		assign fetch_hit[i] = running && insn_exec && cond == PBU_COND_FETCH
			&& exec_eq;
		// Stack and vector reads arrive as ordinary data cycles
		assign cycle_ok = bus_valid && !bus_fetch && (cond == PBU_COND_RW
			|| (cond == PBU_COND_READ && !bus_write)
			|| (cond == PBU_COND_WRITE && bus_write));
		assign data_hit = running && cycle_ok && bus_eq
			&& (!bus_dtc || any_master);
		assign nap_hit[i] = running && sleep_exec && cond == PBU_COND_FETCH
			&& next_eq && sleep_kind == PBU_SLP_NAP;
		assign standby_hit[i] = running && sleep_exec && cond == PBU_COND_FETCH
			&& next_eq && sleep_kind == PBU_SLP_STANDBY;
		// Extra state cases for this channel
		assign extra_term[i] = (bus_valid && !bus_fetch && bus_onchip
			&& cond == PBU_COND_FETCH && bus_eq)
			|| (fetch_hit[i] && prev_slow);

		// Next values for this channel's registers and pending state
		always_comb begin
			next_addr = match_addr[i];
			next_ctrl = ctrl[i];
			if (running && addr_write[i]) begin
				next_addr = addr_wdata;
			end
			if (running && ctrl_write[i]) begin
				next_ctrl = ctrl_wdata[6:0];
			end
			// Data hits park until the instruction is over
			next_pd = pend_data[i];
			set_flag = fetch_hit[i] || nap_hit[i] || standby_hit[i];
			if (data_hit && !bus_dtc) begin
				next_pd = 1'b1;
			end else if (pend_data[i] && insn_end && !block_move_busy) begin
				next_pd = 1'b0;
				set_flag = 1'b1;
			end
			// Transfer-controller hits wait for its run, then for the bus
			next_pt = pend_dtc[i];
			next_dd = dtc_done[i];
			if (data_hit && bus_dtc) begin
				next_pt = 1'b1;
			end else if (pend_dtc[i] && (xfer_count_done || xfer_irq_sel_done)) begin
				next_dd = 1'b1;
			end else if (dtc_done[i] && cpu_owns_bus) begin
				next_pt = 1'b0;
				next_dd = 1'b0;
				set_flag = 1'b1;
			end
			// Mode switch first, break afterwards
			next_ps = pend_switch[i];
			if (running && sleep_exec && cond == PBU_COND_FETCH && next_eq
				&& sleep_kind == PBU_SLP_SWITCH) begin
				next_ps = 1'b1;
			end else if (pend_switch[i] && mode_switch_done) begin
				next_ps = 1'b0;
				set_flag = 1'b1;
			end
			// Clear only after a read saw 1; a same-cycle set wins
			clr_flag = running && ctrl_write[i] && !ctrl_wdata[`PBU_CTL_FLAG]
				&& armed[i];
			next_flag = set_flag || (flag[i] && !clr_flag);
			next_armed = armed[i];
			if (running && ctrl_write[i]) begin
				next_armed = 1'b0;
			end else if (running && ctrl_read[i] && flag[i]) begin
				next_armed = 1'b1;
			end
		end

		// Channel registers
		always_ff @(posedge clk or posedge reset) begin
			if (reset) begin
				match_addr[i] <= `PBU_ADDR_RESET;
				ctrl[i] <= `PBU_CTL_RESET;
				flag[i] <= 1'b0;
				armed[i] <= 1'b0;
				pend_data[i] <= 1'b0;
				pend_dtc[i] <= 1'b0;
				dtc_done[i] <= 1'b0;
				pend_switch[i] <= 1'b0;
			end else begin
				match_addr[i] <= next_addr;
				ctrl[i] <= next_ctrl;
				flag[i] <= next_flag;
				armed[i] <= next_armed;
				pend_data[i] <= next_pd;
				pend_dtc[i] <= next_pt;
				dtc_done[i] <= next_dd;
				pend_switch[i] <= next_ps;
			end
		end

		a_fetch_flag: assert property (@(posedge clk) disable iff (reset)
			fetch_hit[i] |=> flag[i]) else $error("fetch hit did not set flag");
		a_data_wait: assert property (@(posedge clk) disable iff (reset)
			pend_data[i] && block_move_busy |=> pend_data[i])
			else $error("data break released during block move");
		a_data_release: assert property (@(posedge clk) disable iff (reset)
			pend_data[i] && insn_end && !block_move_busy |=> flag[i] && !pend_data[i])
			else $error("data break not flagged at instruction end");
		a_dtc_bus: assert property (@(posedge clk) disable iff (reset)
			pend_dtc[i] && !cpu_owns_bus |=> pend_dtc[i])
			else $error("transfer break released without bus");
		a_flag_sticky: assert property (@(posedge clk) disable iff (reset)
			flag[i] && !(ctrl_write[i] && !ctrl_wdata[7] && armed[i]) |=> flag[i])
			else $error("flag cleared without read-then-write");
		a_stop_frozen: assert property (@(posedge clk) disable iff (reset)
			module_stop |=> ctrl[i] == $past(ctrl[i]) && match_addr[i] == $past(match_addr[i]))
			else $error("register changed under module stop");
		a_mask_wide: assert property (@(posedge clk) disable iff (reset)
			ctrl[i][5:3] == 3'h7 && exec_addr[23:16] == match_addr[i][23:16] |-> exec_eq)
			else $error("16-bit mask not honoured");
		c_data_break: cover property (@(posedge clk) disable iff (reset)
			pend_data[i] ##[1:20] flag[i]);
	end

	// Shared request, extra state and sleep suppression
	always_comb begin
		next_irq = 1'b0;
		next_extra = 1'b0;
		next_suppress = 1'b0;
		next_standby_hold = standby_hold && !insn_exec; // Released once code runs again
		for (int i = 0; i < NCH; i++) begin
			if (flag[i] && ctrl[i][`PBU_CTL_IE]) begin
				next_irq = 1'b1;
			end
			if (extra_term[i] || (ctrl[i][`PBU_CTL_IE] && insn_exec
				&& insn_branch1 && insn_onchip)) begin
				next_extra = running;
			end
			if (nap_hit[i]) begin
				next_suppress = 1'b1;
			end
			if (standby_hit[i]) begin
				next_standby_hold = 1'b1;
			end
		end
		// Interrupt window closes for three states after a mask load
		next_block = block_cnt;
		if (mask_update) begin
			next_block = 2'(`PBU_IBLOCK_STATES - 1);
		end else if (block_cnt != 2'h0) begin
			next_block = block_cnt - 2'h1;
		end
		next_irq = next_irq && running && !standby_hold && !next_standby_hold
			&& !mask_update && block_cnt == 2'h0;
	end

	// Shared outputs, all registered
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			break_irq <= 1'b0;
			extra_state <= 1'b0;
			suppress_sleep <= 1'b0;
			standby_hold <= 1'b0;
			block_cnt <= 2'h0;
		end else begin
			break_irq <= next_irq;
			extra_state <= next_extra;
			suppress_sleep <= next_suppress;
			standby_hold <= next_standby_hold;
			block_cnt <= next_block;
		end
	end

	a_irq_enable: assert property (@(posedge clk) disable iff (reset)
		break_irq |-> $past(flag[0] && ctrl[0][0] || flag[1] && ctrl[1][0]))
		else $error("interrupt without enabled flag");
	a_irq_block: assert property (@(posedge clk) disable iff (reset)
		mask_update |=> !break_irq [*3]) else $error("interrupt inside mask window");
	a_nap_suppress: assert property (@(posedge clk) disable iff (reset)
		nap_hit[0] || nap_hit[1] |=> suppress_sleep)
		else $error("nap sleep not suppressed");
	a_standby_quiet: assert property (@(posedge clk) disable iff (reset)
		standby_hit[0] || standby_hit[1] |=> !break_irq)
		else $error("break taken on standby entry");
	c_irq: cover property (@(posedge clk) disable iff (reset) $rose(break_irq));
	c_extra: cover property (@(posedge clk) disable iff (reset) extra_state);
	c_nap: cover property (@(posedge clk) disable iff (reset) suppress_sleep);
endmodule // pbu_break
`default_nettype wire

// ===== test/pbu_xfer_model.sv
`timescale 1ns/100ps
`default_nettype none
module pbu_xfer_model (
	input wire logic clk,
	input wire logic reset,
	input wire logic start,
	output logic cpu_owns_bus,
	output logic xfer_count_done
);
	logic [3:0] cnt;
	logic [3:0] next_cnt;
	// Burst: take the bus, end the count, hand the bus back late on purpose
	always_comb begin
		next_cnt = cnt;
		if (start) begin
			next_cnt = 4'h1;
		end else if (cnt == 4'h8) begin
			next_cnt = 4'h0;
		end else if (cnt != 4'h0) begin
			next_cnt = cnt + 4'h1;
		end
	end
	// Bus returns four cycles after the count ends, so a hasty unit shows
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			cnt <= 4'h0;
			cpu_owns_bus <= 1'b1;
			xfer_count_done <= 1'b0;
		end else begin
			cnt <= next_cnt;
			cpu_owns_bus <= (next_cnt == 4'h0);
			xfer_count_done <= (next_cnt == 4'h5);
		end
	end
endmodule // pbu_xfer_model
`default_nettype wire

// ===== test/tb_program_break_comparator.sv
`timescale 1ns/100ps
`default_nettype none
module tb_program_break_comparator;
	import pbu_pkg::*;
	logic clk = 0, reset = 1, module_stop = 1, bus_valid = 0, bus_fetch = 0, bus_write = 0;
	logic bus_dtc = 0, bus_onchip = 0, insn_exec = 0, insn_branch1 = 0, insn_onchip = 0;
	logic prev_slow = 0, insn_end = 0, block_move_busy = 0, xfer_irq_sel_done = 0;
	logic sleep_exec = 0, mode_switch_done = 0, mask_update = 0, xfer_start = 0;
	logic [1:0] addr_write = 0, ctrl_write = 0, ctrl_read = 0;
	logic [7:0] ctrl_wdata = 0;
	logic [23:0] addr_wdata = 0, bus_addr = 0, exec_addr = 0, sleep_next_addr = 0;
	pbu_sleep_t sleep_kind = PBU_SLP_NAP;
	wire logic [23:0] chan_a_match_address, chan_b_match_address;
	wire logic [7:0] chan_a_break_control, chan_b_break_control;
	logic break_irq, extra_state, suppress_sleep, cpu_owns_bus, xfer_count_done;
	int err_count = 0, n_checks = 0;
	// Free-running 20 MHz clock
	always #25 clk = ~clk;
	pbu_break dut_u (.clk, .reset, .module_stop, .addr_write, .addr_wdata, .ctrl_write,
		.ctrl_wdata, .ctrl_read, .bus_valid, .bus_fetch, .bus_write, .bus_dtc, .bus_onchip,
		.bus_addr, .insn_exec, .exec_addr, .insn_branch1, .insn_onchip, .prev_slow, .insn_end,
		.block_move_busy, .xfer_count_done, .xfer_irq_sel_done, .cpu_owns_bus, .sleep_exec,
		.sleep_kind, .sleep_next_addr, .mode_switch_done, .mask_update, .chan_a_match_address,
		.chan_b_match_address, .chan_a_break_control, .chan_b_break_control, .break_irq,
		.extra_state, .suppress_sleep);
	pbu_xfer_model xfer_u (.clk, .reset, .start(xfer_start), .cpu_owns_bus, .xfer_count_done);
	// Shared compare, four-state so an unknown never passes
	task automatic chk(input string what, input logic [23:0] seen, input logic [23:0] exp);
		n_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(negedge clk);
	endtask
	// One register write, held for exactly one sampling edge
	task automatic wr(input int ch, input logic ctl, input logic [23:0] d);
		@(posedge clk);
		if (ctl) begin
			ctrl_write[ch] <= 1'b1;
			ctrl_wdata <= d[7:0];
		end else begin
			addr_write[ch] <= 1'b1;
			addr_wdata <= d;
		end
		@(posedge clk);
		ctrl_write <= 2'h0;
		addr_write <= 2'h0;
	endtask
	// Flag clear needs a read as one first
	task automatic clr(input int ch, input logic [7:0] c);
		@(posedge clk);
		ctrl_read[ch] <= 1'b1;
		@(posedge clk);
		ctrl_read <= 2'h0;
		wr(ch, 1'b1, {16'h0000, c});
	endtask
	task automatic bus(input logic [23:0] a, input logic w, input logic transfer_controller);
		@(posedge clk);
		bus_valid <= 1'b1;
		bus_addr <= a;
		bus_write <= w;
		bus_dtc <= transfer_controller;
		@(posedge clk);
		bus_valid <= 1'b0;
		bus_dtc <= 1'b0;
	endtask
	// One-cycle strobe; exec_addr rides along for fetch compares
	localparam int P_EXEC = 0, P_END = 1, P_XFER = 2, P_SLEEP = 3;
	localparam int P_MASK = 4, P_SWDONE = 5, P_SEL = 6;
	task automatic pulse(input int sel, input logic [23:0] a);
		@(posedge clk);
		exec_addr <= a;
		case (sel)
			P_EXEC: insn_exec <= 1'b1;
			P_END: insn_end <= 1'b1;
			P_XFER: xfer_start <= 1'b1;
			P_SLEEP: sleep_exec <= 1'b1;
			P_MASK: mask_update <= 1'b1;
			P_SWDONE: mode_switch_done <= 1'b1;
			default: xfer_irq_sel_done <= 1'b1;
		endcase
		@(posedge clk);
		insn_exec <= 1'b0;
		insn_end <= 1'b0;
		xfer_start <= 1'b0;
		sleep_exec <= 1'b0;
		mask_update <= 1'b0;
		mode_switch_done <= 1'b0;
		xfer_irq_sel_done <= 1'b0;
	endtask
	task automatic t_stop();
		wr(0, 1'b1, 24'h00_0001);
		tick(1);
		chk("ctrl_a_stopped", chan_a_break_control, 24'h00_0000);
		chk("addr_a_reset", chan_a_match_address, 24'h00_0000);
		@(posedge clk);
		module_stop <= 1'b0;
	endtask
	// Fetch break, 8 low bits ignored, branch on chip so one extra state
	task automatic t_fetch();
		wr(0, 1'b0, 24'h12_3450);
		wr(0, 1'b1, 24'h00_0029);
		tick(1);
		chk("addr_a", chan_a_match_address, 24'h12_3450);
		pulse(P_EXEC, 24'h12_3550);
		tick(2);
		chk("miss_flag", chan_a_break_control, 24'h00_0029);
		@(posedge clk);
		insn_branch1 <= 1'b1;
		insn_onchip <= 1'b1;
		pulse(P_EXEC, 24'h12_34ab);
		insn_branch1 <= 1'b0;
		insn_onchip <= 1'b0;
		tick(1);
		chk("fetch_flag", chan_a_break_control, 24'h00_00a9);
		chk("extra", extra_state, 24'h00_0001);
		tick(1);
		chk("fetch_irq", break_irq, 24'h00_0001);
		wr(0, 1'b1, 24'h00_0029);
		tick(1);
		chk("sticky", chan_a_break_control, 24'h00_00a9);
		clr(0, 8'h29);
		tick(2);
		chk("cleared", chan_a_break_control, 24'h00_0029);
		chk("irq_off", break_irq, 24'h00_0000);
	endtask
	// Write break on channel b, no enable; block move defers it
	task automatic t_data();
		wr(1, 1'b0, 24'h00_ff10);
		wr(1, 1'b1, 24'h00_0004);
		tick(1);
		chk("addr_b", chan_b_match_address, 24'h00_ff10);
		bus(24'h00_ff10, 1'b0, 1'b0);
		bus(24'h00_ff11, 1'b1, 1'b0);
		bus(24'h00_ff10, 1'b1, 1'b0);
		block_move_busy <= 1'b1;
		pulse(P_END, 24'h00_0000);
		tick(2);
		chk("data_early", chan_b_break_control, 24'h00_0004);
		@(posedge clk);
		block_move_busy <= 1'b0;
		pulse(P_END, 24'h00_0000);
		tick(1);
		chk("data_flag", chan_b_break_control, 24'h00_0084);
		tick(1);
		chk("irq_gated", break_irq, 24'h00_0000);
		clr(1, 8'h46);
	endtask
	// Transfer-controller read; flag waits for bus to return
	task automatic t_xfer();
		pulse(P_XFER, 24'h00_0000);
		bus(24'h00_ff10, 1'b0, 1'b1);
		for (int i = 0; i < 20 && cpu_owns_bus !== 1'b1; i++) begin
			tick(1);
			chk("xfer_hold", chan_b_break_control[7], 24'h00_0000);
		end
		tick(2);
		chk("xfer_flag", chan_b_break_control, 24'h00_00c6);
	endtask
	// Nap sleep is suppressed; mask update blocks the request briefly
	task automatic t_sleep();
		wr(0, 1'b0, 24'h00_2000);
		wr(0, 1'b1, 24'h00_0001);
		sleep_next_addr <= 24'h00_2000;
		pulse(P_SLEEP, 24'h00_0000);
		tick(1);
		chk("nap_block", suppress_sleep, 24'h00_0001);
		chk("nap_flag", chan_a_break_control, 24'h00_0081);
		tick(1);
		chk("nap_pulse", suppress_sleep, 24'h00_0000);
		pulse(P_MASK, 24'h00_0000);
		tick(2);
		chk("mask_irq", break_irq, 24'h00_0000);
		tick(4);
		chk("irq_back", break_irq, 24'h00_0001);
	endtask
	// Data touch of a fetch-break address, slow predecessor: one extra state each
	task automatic t_extra();
		@(posedge clk);
		bus_onchip <= 1'b1;
		bus(24'h00_2000, 1'b0, 1'b0);
		bus_onchip <= 1'b0;
		tick(1);
		chk("extra_data", extra_state, 24'h00_0001);
		@(posedge clk);
		prev_slow <= 1'b1;
		pulse(P_EXEC, 24'h00_2001);
		tick(1);
		chk("extra_miss", extra_state, 24'h00_0000);
		pulse(P_EXEC, 24'h00_2000);
		tick(1);
		chk("extra_slow", extra_state, 24'h00_0001);
		@(posedge clk);
		prev_slow <= 1'b0;
	endtask
	// Standby holds the request until code runs; a mode switch goes first
	task automatic t_power();
		clr(0, 8'h01);
		sleep_kind <= PBU_SLP_STANDBY;
		pulse(P_SLEEP, 24'h00_0000);
		tick(2);
		chk("standby_irq", break_irq, 24'h00_0000);
		chk("standby_flag", chan_a_break_control, 24'h00_0081);
		pulse(P_EXEC, 24'h12_3550);
		tick(2);
		chk("wake_irq", break_irq, 24'h00_0001);
		clr(0, 8'h01);
		sleep_kind <= PBU_SLP_SWITCH;
		pulse(P_SLEEP, 24'h00_0000);
		tick(2);
		chk("switch_early", chan_a_break_control, 24'h00_0001);
		pulse(P_SWDONE, 24'h00_0000);
		tick(1);
		chk("switch_flag", chan_a_break_control, 24'h00_0081);
	endtask
	// Per-transfer select ends the wait without a finished count
	task automatic t_select();
		clr(1, 8'h46);
		bus(24'h00_ff10, 1'b1, 1'b1);
		tick(2);
		chk("select_early", chan_b_break_control, 24'h00_0046);
		pulse(P_SEL, 24'h00_0000);
		tick(2);
		chk("select_flag", chan_b_break_control, 24'h00_00c6);
	endtask
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	// Main sequence after six reset cycles
	initial begin
		repeat (6) @(posedge clk);
		reset <= 1'b0;
		t_stop();
		t_fetch();
		t_data();
		t_xfer();
		t_sleep();
		t_extra();
		t_power();
		t_select();
		print_verdict();
	end
	// Watchdog, far beyond the 112 or so cycles the tests need
	initial begin
		#200000;
		err_count++;
		print_verdict();
	end
endmodule // tb_program_break_comparator
`default_nettype wire
